// file: rtl/credit_mon_pkg.sv
// constants shared by the credit event monitor files
package credit_mon_pkg;
    // ************************************************************
    // event codes and unit mask layout
    // ************************************************************
    localparam logic [7:0] EVT_RES1_REJECT   = 8'h39;
    localparam logic [7:0] EVT_RES1_USE      = 8'h38;
    localparam logic [7:0] EVT_SHR_ACQUIRE   = 8'h33;
    localparam logic [7:0] EVT_SHR_REJECT    = 8'h34;
    localparam int         CODE_LSB          = 0;
    localparam int         UMASK_LSB         = 8;
    localparam int         UMASK_MSB         = 15;
    localparam int         ENABLE_BIT        = 22;
    localparam int         RING_REQ_BIT      = 0;
    localparam int         RING_PAYLOAD_BIT  = 2;
    localparam int         NUM_CLASS         = 6;
    localparam int         NUM_CNT           = 2;

    // message classes, bit position in the unit mask
    localparam logic [2:0] CLS_REQ_RESP      = 3'h0;
    localparam logic [2:0] CLS_SNOOP         = 3'h1;
    localparam logic [2:0] CLS_NODATA_RESP   = 3'h2;
    localparam logic [2:0] CLS_DATA_RESP     = 3'h3;
    localparam logic [2:0] CLS_NC_BYPASS     = 3'h4;
    localparam logic [2:0] CLS_NC_STANDARD   = 3'h5;

    // ************************************************************
    // credit pools
    // ************************************************************
    localparam logic [5:0] SHARED_POOL_SIZE  = 6'h20;
    localparam logic [1:0] RES1_POOL_SIZE    = 2'h2;
    localparam logic [2:0] MAX_ACQ_PER_CYC   = 3'h4;

    // ************************************************************
    // apb register map and reset values
    // ************************************************************
    localparam logic [7:0]  ADDR_SEL0        = 8'h00;
    localparam logic [7:0]  ADDR_SEL1        = 8'h04;
    localparam logic [7:0]  ADDR_CNT0        = 8'h08;
    localparam logic [7:0]  ADDR_CNT1        = 8'h0c;
    localparam logic [7:0]  ADDR_POOL        = 8'h10;
    localparam logic [31:0] SEL_RESET        = 32'h0000_0000;
    localparam logic [31:0] SEL_WRITE_MASK   = 32'h0040_ffff;
    localparam logic [31:0] CNT_RESET        = 32'h0000_0000;
endpackage : credit_mon_pkg

// file: rtl/credit_event_match.sv
// one counter's event selector: turns per-cycle credit events into an increment
`timescale 1ns/1ps
`default_nettype none
module credit_event_match (
    input  wire logic [31:0] sel,
    input  wire logic [5:0]  res1_reject_cls,
    input  wire logic [5:0]  res1_use_cls,
    input  wire logic [5:0]  shr_reject_cls,
    input  wire logic [2:0]  shr_acq_req_ring,
    input  wire logic [2:0]  shr_acq_payload_ring,
    output logic      [2:0]  inc
);
    logic [7:0] code;
    logic [7:0] umask;
    logic       en;

    assign code  = sel[credit_mon_pkg::CODE_LSB +: 8];
    assign umask = sel[credit_mon_pkg::UMASK_MSB:credit_mon_pkg::UMASK_LSB];
    assign en    = sel[credit_mon_pkg::ENABLE_BIT];

    // ************************************************************
    // event decode
    // ************************************************************
    // class events are a union over the selected classes, so one per cycle at most
    always_comb begin
        inc = 3'h0;
        if (en) begin
            unique case (code)
                credit_mon_pkg::EVT_RES1_REJECT:
                    inc = {2'h0, |(res1_reject_cls & umask[5:0])};         // [R1] [R12]
                credit_mon_pkg::EVT_RES1_USE:
                    inc = {2'h0, |(res1_use_cls & umask[5:0])};            // [R2] [R3] [R12]
                credit_mon_pkg::EVT_SHR_REJECT:
                    inc = {2'h0, |(shr_reject_cls & umask[5:0])};          // [R7] [R9] [R12]
                credit_mon_pkg::EVT_SHR_ACQUIRE: begin
                    // ring select only, no class filter; one request per cycle
                    // means only one ring carries credits, so the sum stays <= 4
                    if (umask[credit_mon_pkg::RING_REQ_BIT])
                        inc = shr_acq_req_ring;                            // [R5] [R6]
                    if (umask[credit_mon_pkg::RING_PAYLOAD_BIT])
                        inc = inc | shr_acq_payload_ring;                  // [R6] [R12]
                end
                default: inc = 3'h0;
            endcase
        end
    end
endmodule : credit_event_match
`default_nettype wire

// file: rtl/link_credit_event_monitor.sv
// link credit allocator with four credit events counted on two apb counters
// What this block does
// R1: code 0x39 counts requests rejected by both pools
// R2: code 0x38 counts reserved pool one uses
// R3: reserved pool one transfer counts once
// R4: shared pool tried first, then reserved one
// R5: code 0x33 adds shared credits acquired, max four
// R6: acquire mask selects request or payload ring
// R7: code 0x34 counts shared pool rejects
// R8: reject when packet cannot get all credits
// R9: shared reject supports class filter
// R10: class mask in select bits 15 to 8
// R11: these events exist on counters 0-1 only
// R12: several mask bits count the union
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module link_credit_event_monitor (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // credit request from the link layer, one per cycle
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_class,
    input  wire logic [2:0]  req_flits,
    input  wire logic        req_payload_ring,
    // credit returns from the far side
    input  wire logic [2:0]  ret_shared_count,
    input  wire logic        ret_res1_valid,
    input  wire logic [2:0]  ret_res1_class,
    // allocation results, one cycle after the request
    output logic             grant_shared,
    output logic             grant_res1,
    output logic             grant_reject
);
    // ************************************************************
    // state
    // ************************************************************
    logic [5:0]  shared_lvl_ff;
    logic [1:0]  res1_lvl_ff [credit_mon_pkg::NUM_CLASS];
    logic [31:0] sel_ff      [credit_mon_pkg::NUM_CNT];
    logic [31:0] cnt_ff      [credit_mon_pkg::NUM_CNT];
    logic [2:0]  inc         [credit_mon_pkg::NUM_CNT];
    logic [5:0]  res1_reject_cls_ff;
    logic [5:0]  res1_use_cls_ff;
    logic [5:0]  shr_reject_cls_ff;
    logic [2:0]  shr_acq_req_ff;
    logic [2:0]  shr_acq_pay_ff;
    logic        grant_shared_ff;
    logic        grant_res1_ff;
    logic        grant_reject_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    // ************************************************************
    // allocation decision
    // ************************************************************
    logic       cls_ok;
    logic [5:0] cls_onehot;
    logic       nxt_take_shared;
    logic       nxt_take_res1;
    logic       nxt_reject;
    logic [2:0] nxt_acq;

    assign cls_ok     = req_valid && (req_class <= credit_mon_pkg::CLS_NC_STANDARD)
                        && (req_flits != 3'h0)
                        && (req_flits <= credit_mon_pkg::MAX_ACQ_PER_CYC);
    assign cls_onehot = cls_ok ? (6'h01 << req_class) : 6'h00;

    // shared first, reserved one only on a shared miss
    always_comb begin
        nxt_take_shared = 1'b0;
        nxt_take_res1   = 1'b0;
        nxt_reject      = 1'b0;
        nxt_acq         = 3'h0;
        if (cls_ok) begin
            // every flit must fit; a partial fit is still a shared reject
            if ({3'h0, req_flits} <= shared_lvl_ff) begin                // [R4] [R8]
                nxt_take_shared = 1'b1;
                nxt_acq         = req_flits;                             // [R5]
            end else if (res1_lvl_ff[req_class] != 2'h0) begin           // [R4]
                nxt_take_res1 = 1'b1;
            end else begin
                nxt_reject = 1'b1;                                       // [R1]
            end
        end
    end

    // ************************************************************
    // shared pool level
    // ************************************************************
    // returns above the pool size are clipped so a faulty peer cannot wrap it
    logic [6:0] shr_sum;
    assign shr_sum = {1'b0, shared_lvl_ff} + {4'h0, ret_shared_count} - {4'h0, nxt_acq};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_lvl_ff <= credit_mon_pkg::SHARED_POOL_SIZE;
        end else if (shr_sum > {1'b0, credit_mon_pkg::SHARED_POOL_SIZE}) begin
            shared_lvl_ff <= credit_mon_pkg::SHARED_POOL_SIZE;
        end else begin
            shared_lvl_ff <= shr_sum[5:0];
        end
    end

    // ************************************************************
    // reserved pool one, one counter per class
    // ************************************************************
    // a transfer holds one credit however many flit buffers it fills
    genvar gc;
    generate
        for (gc = 0; gc < credit_mon_pkg::NUM_CLASS; gc++) begin : g_res1
            logic take;
            logic give;
            assign take = nxt_take_res1 && cls_onehot[gc];               // [R3]
            assign give = ret_res1_valid && (ret_res1_class == 3'(gc))
                          && (res1_lvl_ff[gc] != credit_mon_pkg::RES1_POOL_SIZE);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    res1_lvl_ff[gc] <= credit_mon_pkg::RES1_POOL_SIZE;
                end else if (take && !give) begin
                    res1_lvl_ff[gc] <= res1_lvl_ff[gc] - 2'h1;
                end else if (give && !take) begin
                    res1_lvl_ff[gc] <= res1_lvl_ff[gc] + 2'h1;
                end
            end
        end
    endgenerate

    // ************************************************************
    // allocation outputs and event flags
    // ************************************************************
    // registered so counters see a clean one-cycle pulse per event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_shared_ff    <= 1'b0;
            grant_res1_ff      <= 1'b0;
            grant_reject_ff    <= 1'b0;
            res1_reject_cls_ff <= 6'h00;
            res1_use_cls_ff    <= 6'h00;
            shr_reject_cls_ff  <= 6'h00;
            shr_acq_req_ff     <= 3'h0;
            shr_acq_pay_ff     <= 3'h0;
        end else begin
            grant_shared_ff    <= nxt_take_shared;
            grant_res1_ff      <= nxt_take_res1;
            grant_reject_ff    <= nxt_reject;
            res1_reject_cls_ff <= nxt_reject ? cls_onehot : 6'h00;       // [R1]
            res1_use_cls_ff    <= nxt_take_res1 ? cls_onehot : 6'h00;    // [R2] [R3]
            // a shared miss is a shared reject even if reserved one then wins
            shr_reject_cls_ff  <= (nxt_take_res1 || nxt_reject)
                                  ? cls_onehot : 6'h00;                  // [R7] [R8]
            shr_acq_req_ff     <= req_payload_ring ? 3'h0 : nxt_acq;     // [R6]
            shr_acq_pay_ff     <= req_payload_ring ? nxt_acq : 3'h0;     // [R6]
        end
    end

    // ************************************************************
    // counters 0 and 1
    // ************************************************************
    logic       apb_write;
    logic       apb_done;
    assign apb_done  = psel && penable && pready_ff;
    assign apb_write = apb_done && pwrite;

    // only two counters exist, nothing else can take these events
    genvar gn;
    generate
        for (gn = 0; gn < credit_mon_pkg::NUM_CNT; gn++) begin : g_cnt    // [R11]
            logic [7:0] sel_addr;
            logic [7:0] cnt_addr;
            assign sel_addr = credit_mon_pkg::ADDR_SEL0 + 8'(4 * gn);
            assign cnt_addr = credit_mon_pkg::ADDR_CNT0 + 8'(4 * gn);

            credit_event_match u_match (
                .sel                  (sel_ff[gn]),
                .res1_reject_cls      (res1_reject_cls_ff),
                .res1_use_cls         (res1_use_cls_ff),
                .shr_reject_cls       (shr_reject_cls_ff),
                .shr_acq_req_ring     (shr_acq_req_ff),
                .shr_acq_payload_ring (shr_acq_pay_ff),
                .inc                  (inc[gn])
            );

            // select register: code, class mask in 15:8, enable
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sel_ff[gn] <= credit_mon_pkg::SEL_RESET;
                end else if (apb_write && paddr == sel_addr) begin
                    sel_ff[gn] <= pwdata & credit_mon_pkg::SEL_WRITE_MASK; // [R10]
                end
            end

            // software write loads the counter and wins over a same-cycle event
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_ff[gn] <= credit_mon_pkg::CNT_RESET;
                end else if (apb_write && paddr == cnt_addr) begin
                    cnt_ff[gn] <= pwdata;
                end else begin
                    cnt_ff[gn] <= cnt_ff[gn] + {29'h0, inc[gn]};
                end
            end
        end
    endgenerate

    // ************************************************************
    // apb slave
    // ************************************************************
    logic        addr_ok;
    logic [31:0] rd_mux;

    assign addr_ok = (paddr == credit_mon_pkg::ADDR_SEL0) ||
                     (paddr == credit_mon_pkg::ADDR_SEL1) ||
                     (paddr == credit_mon_pkg::ADDR_CNT0) ||
                     (paddr == credit_mon_pkg::ADDR_CNT1) ||
                     (paddr == credit_mon_pkg::ADDR_POOL);

    // read mux; the pool word shows live credit levels
    always_comb begin
        unique case (paddr)
            credit_mon_pkg::ADDR_SEL0: rd_mux = sel_ff[0];
            credit_mon_pkg::ADDR_SEL1: rd_mux = sel_ff[1];
            credit_mon_pkg::ADDR_CNT0: rd_mux = cnt_ff[0];
            credit_mon_pkg::ADDR_CNT1: rd_mux = cnt_ff[1];
            credit_mon_pkg::ADDR_POOL: rd_mux = {14'h0000,
                                                 res1_lvl_ff[5], res1_lvl_ff[4],
                                                 res1_lvl_ff[3], res1_lvl_ff[2],
                                                 res1_lvl_ff[1], res1_lvl_ff[0],
                                                 shared_lvl_ff};
            default:                   rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !addr_ok;
            prdata_ff  <= (!pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign grant_shared = grant_shared_ff;
    assign grant_res1   = grant_res1_ff;
    assign grant_reject = grant_reject_ff;
endmodule : link_credit_event_monitor
`default_nettype wire

// file: tb/credit_mon_monitor.sv
// port-level assertions for the link credit event monitor
`timescale 1ns/1ps
`default_nettype none
module credit_mon_monitor (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_class,
    input  wire logic [2:0]  req_flits,
    input  wire logic        grant_shared,
    input  wire logic        grant_res1,
    input  wire logic        grant_reject
);
    // ************************************************************
    // helpers and checks
    // ************************************************************
    logic       vreq;
    logic [2:0] gnt;
    logic       mapped;

    // out-of-range class or flit count must get no answer at all
    assign vreq   = req_valid && (req_class <= 3'h5) && (req_flits != 3'h0) && (req_flits <= 3'h4);
    assign gnt    = {grant_reject, grant_res1, grant_shared};
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    grant_onehot_a: assert property ($onehot0(gnt))
        else $error("two grants in one cycle");
    grant_answer_a: assert property (vreq |=> $onehot(gnt))
        else $error("valid request without exactly one grant");
    grant_idle_a: assert property (!vreq |=> gnt == 3'h0)
        else $error("grant without a valid request");
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside pready");
    map_error_a: assert property (psel && penable && pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
endmodule : credit_mon_monitor
`default_nettype wire

// file: tb/link_credit_event_monitor_tb_top.sv
// self-checking bench for the link credit event monitor
`timescale 1ns/1ps
`default_nettype none
module link_credit_event_monitor_tb_top;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] mask;
        logic       en;
        logic [2:0] cls;
        logic [2:0] flits;
        logic       ring;
        logic [2:0] gnt;
        logic [2:0] inc;
    } row_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        req_valid = 1'b0;
    logic [2:0]  req_class = 3'h0;
    logic [2:0]  req_flits = 3'h1;
    logic        req_payload_ring = 1'b0;
    logic [2:0]  ret_shared_count = 3'h0;
    logic        ret_res1_valid = 1'b0;
    logic [2:0]  ret_res1_class = 3'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, grant_shared, grant_res1, grant_reject;
    wire  [2:0]  gnt = {grant_reject, grant_res1, grant_shared};
    int          num_errors = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  sa, ca;
    row_t        rows [19];

    always #5 pclk = ~pclk;

    link_credit_event_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_class(req_class),
        .req_flits(req_flits), .req_payload_ring(req_payload_ring),
        .ret_shared_count(ret_shared_count), .ret_res1_valid(ret_res1_valid),
        .ret_res1_class(ret_res1_class), .grant_shared(grant_shared),
        .grant_res1(grant_res1), .grant_reject(grant_reject));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check(32'(n), 32'h2);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one request; returns just after the edge that answers it
    task automatic req(input logic [2:0] c, input logic [2:0] f, input logic r);
        @(posedge pclk);
        req_valid        <= 1'b1;
        req_class        <= c;
        req_flits        <= f;
        req_payload_ring <= r;
        @(posedge pclk);
        req_valid        <= 1'b0;
        #1;
    endtask : req

    task automatic report_and_stop();
        $display("errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // a hang ends the run as a failure; the whole run needs a few hundred cycles
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        // code, mask, enable, class, flits, ring, grant, counter step; shared pool starts at 32
        rows = '{'{8'h33,8'h01,1'b1,3'd3,3'd2,1'b0,3'd1,3'd2},
                 '{8'h33,8'h04,1'b1,3'd0,3'd4,1'b1,3'd1,3'd4},
                 '{8'h33,8'h04,1'b1,3'd0,3'd3,1'b0,3'd1,3'd0},
                 '{8'h33,8'h05,1'b1,3'd1,3'd1,1'b1,3'd1,3'd1},
                 '{8'h34,8'h3f,1'b1,3'd2,3'd1,1'b0,3'd1,3'd0},
                 '{8'h38,8'h3f,1'b1,3'd3,3'd1,1'b0,3'd1,3'd0},
                 '{8'h33,8'h05,1'b1,3'd5,3'd4,1'b0,3'd1,3'd4},
                 '{8'h33,8'h05,1'b1,3'd5,3'd4,1'b0,3'd1,3'd4},
                 '{8'h35,8'h3f,1'b1,3'd5,3'd4,1'b0,3'd1,3'd0},
                 '{8'h33,8'h05,1'b1,3'd5,3'd4,1'b0,3'd1,3'd4},
                 '{8'h33,8'h01,1'b1,3'd4,3'd3,1'b0,3'd1,3'd3},
                 '{8'h34,8'h08,1'b1,3'd3,3'd2,1'b0,3'd2,3'd1},
                 '{8'h38,8'h08,1'b1,3'd3,3'd4,1'b0,3'd2,3'd1},
                 '{8'h39,8'h08,1'b1,3'd3,3'd2,1'b0,3'd4,3'd1},
                 '{8'h39,8'h01,1'b1,3'd3,3'd2,1'b0,3'd4,3'd0},
                 '{8'h34,8'h37,1'b1,3'd3,3'd2,1'b0,3'd4,3'd0},
                 '{8'h33,8'h05,1'b0,3'd3,3'd1,1'b0,3'd1,3'd0},
                 '{8'h34,8'h01,1'b1,3'd0,3'd2,1'b0,3'd2,3'd1},
                 '{8'h39,8'h3f,1'b1,3'd3,3'd1,1'b0,3'd4,3'd1}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // alternate rows between the two counters
        foreach (rows[i]) begin
            sa = i[0] ? credit_mon_pkg::ADDR_SEL1 : credit_mon_pkg::ADDR_SEL0;
            ca = i[0] ? credit_mon_pkg::ADDR_CNT1 : credit_mon_pkg::ADDR_CNT0;
            apb(1'b1, sa, {9'h0, rows[i].en, 6'h0, rows[i].mask, rows[i].code});
            apb(1'b1, ca, 32'h0);
            req(rows[i].cls, rows[i].flits, rows[i].ring);
            check({29'h0, gnt}, {29'h0, rows[i].gnt});
            apb(1'b0, ca, 32'h0);
            check(rd, {29'h0, rows[i].inc});
        end
        // unmapped address reads zero with an error; a third counter does not exist
        apb(1'b0, 8'h14, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, credit_mon_pkg::ADDR_SEL1, 32'hffff_ffff);
        apb(1'b0, credit_mon_pkg::ADDR_SEL1, 32'h0);
        check(rd, 32'h0040_ffff);
        // second reset mid-run: registers clear, pools refill
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0);
        end
        // returns into full pools must clip; the status word is read-only
        @(posedge pclk);
        ret_shared_count <= 3'h3;
        ret_res1_valid   <= 1'b1;
        ret_res1_class   <= 3'h4;
        @(posedge pclk);
        ret_shared_count <= 3'h0;
        ret_res1_valid   <= 1'b0;
        apb(1'b1, credit_mon_pkg::ADDR_POOL, 32'h0);
        check({31'h0, er}, 32'h0);
        apb(1'b0, credit_mon_pkg::ADDR_POOL, 32'h0);
        check(rd, 32'h0002_aaa0);
        // back-to-back requests then an invalid class
        apb(1'b1, credit_mon_pkg::ADDR_SEL0, 32'h0040_0133);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_class <= 3'h2;
        req_flits <= 3'h1;
        @(posedge pclk);
        req_flits <= 3'h2;
        #1 check({29'h0, gnt}, 32'h1);
        @(posedge pclk);
        req_class <= 3'h6;
        #1 check({29'h0, gnt}, 32'h1);
        @(posedge pclk);
        req_valid <= 1'b0;
        #1 check({29'h0, gnt}, 32'h0);
        apb(1'b0, credit_mon_pkg::ADDR_CNT0, 32'h0);
        check(rd, 32'h3);
        // three shared credits gone, then two come back below the clip
        apb(1'b0, credit_mon_pkg::ADDR_POOL, 32'h0);
        check(rd, 32'h0002_aa9d);
        @(posedge pclk);
        ret_shared_count <= 3'h2;
        @(posedge pclk);
        ret_shared_count <= 3'h0;
        apb(1'b0, credit_mon_pkg::ADDR_POOL, 32'h0);
        check(rd, 32'h0002_aa9f);
        report_and_stop();
    end
endmodule : link_credit_event_monitor_tb_top

bind link_credit_event_monitor credit_mon_monitor mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_class(req_class), .req_flits(req_flits),
    .grant_shared(grant_shared), .grant_res1(grant_res1), .grant_reject(grant_reject));
`default_nettype wire
